// [rtl/bps_exec.sv]
// module: executes branch, call, peripheral select and no-operation words
// Operation
// [RL1] accumulator test: opcode, 4-bit selector, 14-bit target
// [RL2] bit 17 positive, bit 16 zero
// [RL3] zero is neither positive nor negative
// [RL4] bit 15 negative, bit 14 odd
// [RL5] several selected tests: branch if any holds
// [RL6] indicator branch tests greater, equal, less, common
// [RL7] indicator and state branches use raw target
// [RL8] state selector 0-7 switches, 10 interrupt enable
// [RL9] state selector 11 tests and clears overflow
// [RL10] selectors 12-17 test console switches 0-5
// [RL11] call at target: save pc+1, branch target+1
// [RL12] call at target saves five indicators high
// [RL13] call at zero: save pc+1 at zero
// [RL14] call at zero saves five indicators high
// [RL15] calls two cycles, others one cycle; the code gives peripheral select two cycles as well
// [RL16] peripheral select drives 7-bit unit address
// [RL17] command field gated to the addressed unit
// [RL18] transfer bit set moves one word
// [RL19] direction bit: 0 out, 1 into accumulator
// [RL20] unit status loads four comparison indicators
// [RL21] no-operation only advances program counter
// [RL22] pc and eight index registers 14 bits
// [RL23] indirect unconditional branch reloads saved indicators
// [RL24] failed test: next address, indicators kept
`timescale 1ns/100ps
`default_nettype none
module bps_exec (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               issue,
  input  wire logic [23:0]        instr,
  input  wire logic [13:0]        cur_pc,
  input  wire logic [23:0]        ind_word,
  input  wire logic [23:0]        acc,
  input  wire logic [7:0]         sw_flops,
  input  wire logic               ie_flag,
  input  wire logic [5:0]         console_sw_pin,
  input  wire logic               flag_we,
  input  wire bps_pkg::bps_flags_t flag_wdata,
  input  wire logic               idx_we,
  input  wire logic [2:0]         idx_sel,
  input  wire logic [13:0]        idx_wdata,
  input  wire logic [3:0]         per_status,
  input  wire logic [23:0]        per_rdata,
  output logic                    ready_q,
  output logic                    done_q,
  output logic                    taken_q,
  output logic [13:0]             next_pc_q,
  output bps_pkg::bps_flags_t     flags_q,
  output bps_pkg::bps_mem_t       mem_q,
  output logic                    acc_we_q,
  output logic [23:0]             acc_wdata_q,
  output bps_pkg::bps_per_t       per_q
);

  // sequencer state and next values
  bps_pkg::bps_state_t state_q;      // current step
  bps_pkg::bps_state_t state_d;      // next step
  logic                ready_d;      // may take a word next cycle
  logic                done_d;       // retire pulse
  logic                taken_d;      // branch was taken
  logic [13:0]         next_pc_d;    // next address
  bps_pkg::bps_flags_t flags_d;      // indicators
  bps_pkg::bps_mem_t   mem_d;        // memory write request
  logic                acc_we_d;     // accumulator load pulse
  logic [23:0]         acc_wdata_d;  // accumulator load value
  bps_pkg::bps_per_t   per_d;        // peripheral bundle

  // index registers, idx_q
  logic [13:0] idx_q [8];            // [RL22]

  // console switches come from pins: two flops first
  logic [5:0] cs_meta_q;             // first stage, read only by second
  logic [5:0] cs_sync_q;             // safe to use

  // per-entry index register write
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_idx
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          idx_q[gi] <= bps_pkg::ADDR_RST;
        else if (idx_we && (idx_sel == 3'(gi)))
          idx_q[gi] <= idx_wdata;
      end
    end
  endgenerate

  // console switch synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_meta_q <= 6'h00;
      cs_sync_q <= 6'h00;
    end
    else
    begin
      cs_meta_q <= console_sw_pin;
      cs_sync_q <= cs_meta_q;
    end
  end

  // field decode
  wire logic [5:0]  opc      = instr[bps_pkg::OP_HI:bps_pkg::OP_LO];
  wire logic [3:0]  ksel     = instr[bps_pkg::K_HI:bps_pkg::K_LO]; // [RL1]
  wire logic [13:0] m_raw    = instr[bps_pkg::M_HI:bps_pkg::M_LO];
  wire logic [2:0]  xsel     = instr[bps_pkg::X_HI:bps_pkg::X_LO];
  wire logic        ind_bit  = instr[bps_pkg::I_BIT];
  wire logic        issue_ok = issue && ready_q;

  // opcode strobes
  wire logic is_bru = (opc == bps_pkg::OP_BRU);
  wire logic is_bat = (opc == bps_pkg::OP_BAT);
  wire logic is_boi = (opc == bps_pkg::OP_BOI);
  wire logic is_bos = (opc == bps_pkg::OP_BOS);
  wire logic is_spu = (opc == bps_pkg::OP_SPU);
  wire logic is_bsm = (opc == bps_pkg::OP_BSM);
  wire logic is_bsz = (opc == bps_pkg::OP_BSZ);
  wire logic is_nop = (opc == bps_pkg::OP_NOP);

  // effective address; core supplies the indirect word already fetched
  wire logic [13:0] m_idx = m_raw + idx_q[xsel];
  wire logic [13:0] ea    = ind_bit ? ind_word[bps_pkg::M_HI:bps_pkg::M_LO] : m_idx;
  wire logic [13:0] pc_inc = cur_pc + bps_pkg::PC_STEP;

  // accumulator tests; zero is its own state
  wire logic acc_zero = (acc == bps_pkg::WORD_RST);
  wire logic acc_neg  = acc[23] && !acc_zero;            // [RL3]
  wire logic acc_pos  = !acc[23] && !acc_zero;           // [RL2] [RL3]
  wire logic acc_odd  = acc[0];                          // [RL4]
  wire logic [3:0] bat_src = {acc_pos, acc_zero, acc_neg, acc_odd};
  wire logic bat_hit = |(ksel & bat_src);                // [RL5]

  // indicator tests, any selected one set
  wire logic [3:0] boi_src = {flags_q.gt, flags_q.eq, flags_q.lt, flags_q.cb};
  wire logic boi_hit = |(ksel & boi_src);                // [RL6]

  // state sources; selector picks exactly one
  wire logic [15:0] bos_src = {cs_sync_q, flags_q.ov, ie_flag, sw_flops}; // [RL8] [RL10]
  wire logic bos_hit = bos_src[ksel];

  // conditional branch outcome on raw target
  wire logic cond_op  = is_bat || is_boi || is_bos;
  wire logic cond_hit = (is_bat && bat_hit) || (is_boi && boi_hit) || (is_bos && bos_hit);
  wire logic [13:0] cond_pc = cond_hit ? m_raw : pc_inc; // [RL7] [RL24]

  // saved return word: indicators high, return address low
  wire logic [23:0] save_word = {flags_q, 5'h00, pc_inc}; // [RL11] [RL12] [RL14]

  // next-value logic for the whole sequencer
  always_comb
  begin
    state_d     = state_q;
    ready_d     = ready_q;
    done_d      = 1'b0;
    taken_d     = taken_q;
    next_pc_d   = next_pc_q;
    flags_d     = flag_we ? flag_wdata : flags_q;
    mem_d       = mem_q;
    mem_d.we    = 1'b0;
    acc_we_d    = 1'b0;
    acc_wdata_d = acc_wdata_q;
    per_d       = per_q;
    per_d.sel   = 1'b0;
    case (state_q)
      bps_pkg::ST_IDLE:
      begin
        if (issue_ok)
        begin
          // default retire: next sequential word
          done_d    = 1'b1;
          taken_d   = 1'b0;
          next_pc_d = pc_inc;                            // [RL21]
          if (is_bru)
          begin
            taken_d   = 1'b1;
            next_pc_d = ea;
            // indirect return restores saved indicators
            if (ind_bit)
              flags_d = bps_pkg::bps_flags_t'(ind_word[bps_pkg::SAVE_HI:bps_pkg::SAVE_LO]); // [RL23]
          end
          else if (cond_op)
          begin
            taken_d   = cond_hit;
            next_pc_d = cond_pc;                         // [RL24]
            // overflow test clears the indicator
            if (is_bos && (ksel == bps_pkg::BOS_OV))
              flags_d.ov = 1'b0;                         // [RL9]
          end
          else if (is_bsm || is_bsz)
          begin
            // write now, retire on the second cycle
            done_d    = 1'b0;
            ready_d   = 1'b0;
            taken_d   = 1'b1;
            state_d   = bps_pkg::ST_CALL;               // [RL15]
            mem_d.we  = 1'b1;
            mem_d.addr = is_bsm ? ea : bps_pkg::ZERO_ADDR; // [RL13]
            mem_d.data = save_word;
            next_pc_d = is_bsm ? (ea + bps_pkg::PC_STEP) : ea; // [RL11] [RL13]
          end
          else if (is_spu)
          begin
            // unit answers while select is high
            done_d      = 1'b0;
            ready_d     = 1'b0;
            state_d     = bps_pkg::ST_PER;
            per_d.sel   = 1'b1;
            per_d.unit  = instr[bps_pkg::UNIT_HI:bps_pkg::UNIT_LO]; // [RL16]
            per_d.cmd   = instr[bps_pkg::CMD_HI:bps_pkg::CMD_LO];   // [RL17]
            per_d.xfer  = instr[bps_pkg::XFER_BIT];                 // [RL18]
            per_d.dir   = instr[bps_pkg::DIR_BIT];                  // [RL19]
            per_d.wdata = acc;
          end
        end
      end
      bps_pkg::ST_CALL:
      begin
        // second machine cycle of a call
        done_d  = 1'b1;                                  // [RL15]
        ready_d = 1'b1;
        state_d = bps_pkg::ST_IDLE;
      end
      bps_pkg::ST_PER:
      begin
        // take status, and the word when reading
        flags_d.gt = per_status[3];                      // [RL20]
        flags_d.eq = per_status[2];
        flags_d.lt = per_status[1];
        flags_d.cb = per_status[0];
        if (per_q.xfer && per_q.dir)
        begin
          acc_we_d    = 1'b1;                            // [RL18] [RL19]
          acc_wdata_d = per_rdata;
        end
        done_d  = 1'b1;
        ready_d = 1'b1;
        state_d = bps_pkg::ST_IDLE;
      end
      default:
      begin
        // unknown code: return to idle safely
        ready_d = 1'b1;
        state_d = bps_pkg::ST_IDLE;
      end
    endcase
  end

  // register stage; every output leaves from here
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= bps_pkg::ST_IDLE;
      ready_q     <= 1'b1;
      done_q      <= 1'b0;
      taken_q     <= 1'b0;
      next_pc_q   <= bps_pkg::ADDR_RST;
      flags_q     <= bps_pkg::bps_flags_t'(bps_pkg::FLAGS_RST);
      mem_q       <= '0;
      acc_we_q    <= 1'b0;
      acc_wdata_q <= bps_pkg::WORD_RST;
      per_q       <= '0;
    end
    else
    begin
      state_q     <= state_d;
      ready_q     <= ready_d;
      done_q      <= done_d;
      taken_q     <= taken_d;
      next_pc_q   <= next_pc_d;
      flags_q     <= flags_d;
      mem_q       <= mem_d;
      acc_we_q    <= acc_we_d;
      acc_wdata_q <= acc_wdata_d;
      per_q       <= per_d;
    end
  end

  // checks on the sequencer
  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_bat;
    issue_ok && is_bat |=> done_q && (taken_q == $past(bat_hit));
  endproperty
  a_bat: assert property (p_bat) else $error("accumulator test wrong"); // [RL5]

  property p_zero;
    issue_ok && is_bat && acc_zero && (ksel == 4'ha) |=> !taken_q;
  endproperty
  a_zero: assert property (p_zero) else $error("zero seen as signed"); // [RL3]

  property p_boi_miss;
    issue_ok && is_boi && !boi_hit && !flag_we |=> (next_pc_q == $past(pc_inc))
      && $stable(flags_q);
  endproperty
  a_boi_miss: assert property (p_boi_miss) else $error("miss not sequential"); // [RL24]

  property p_bos_ov;
    issue_ok && is_bos && (ksel == bps_pkg::BOS_OV) |=> !flags_q.ov;
  endproperty
  a_bos_ov: assert property (p_bos_ov) else $error("overflow not cleared"); // [RL9]

  property p_bsm;
    issue_ok && is_bsm |=> mem_q.we && (mem_q.addr == $past(ea)) && !done_q
      ##1 done_q && (next_pc_q == $past(ea, 2) + 14'h0001);
  endproperty
  a_bsm: assert property (p_bsm) else $error("call at target wrong"); // [RL11]

  property p_bsz;
    issue_ok && is_bsz && !flag_we |=> (mem_q.addr == 14'h0000)
      && (mem_q.data[23:19] == $past(flags_q)) && (mem_q.data[13:0] == $past(pc_inc));
  endproperty
  a_bsz: assert property (p_bsz) else $error("call at zero wrong"); // [RL14]

  property p_spu;
    issue_ok && is_spu |=> per_q.sel && (per_q.unit == $past(instr[6:0]))
      && (per_q.cmd == $past(instr[15:8])) ##1 done_q && !per_q.sel;
  endproperty
  a_spu: assert property (p_spu) else $error("select sequence wrong"); // [RL16]

  property p_spu_rd;
    per_q.sel |=> (acc_we_q == $past(per_q.xfer && per_q.dir))
      && (flags_q.gt == $past(per_status[3]));
  endproperty
  a_spu_rd: assert property (p_spu_rd) else $error("select answer lost"); // [RL20]

  property p_nop;
    issue_ok && is_nop |=> done_q && !mem_q.we && !acc_we_q && !per_q.sel
      && (next_pc_q == $past(pc_inc));
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation had effect"); // [RL21]

  property p_bru;
    issue_ok && is_bru && ind_bit |=> flags_q == $past(ind_word[23:19]);
  endproperty
  a_bru: assert property (p_bru) else $error("indicators not restored"); // [RL23]

  // main scenarios
  c_call: cover property (issue_ok && is_bsm);
  c_read: cover property (per_q.sel && per_q.xfer && per_q.dir);
  c_taken: cover property (issue_ok && is_bos && bos_hit);

endmodule // bps_exec
`default_nettype wire

// [rtl/bps_pkg.sv]
// package: constants and carriers for the branch and peripheral select block
package bps_pkg;
  // opcode field values
  localparam logic [5:0] OP_BRU = 6'h01;
  localparam logic [5:0] OP_BAT = 6'h02;
  localparam logic [5:0] OP_BOI = 6'h03;
  localparam logic [5:0] OP_BOS = 6'h04;
  localparam logic [5:0] OP_SPU = 6'h06;
  localparam logic [5:0] OP_NOP = 6'h08;
  localparam logic [5:0] OP_BSM = 6'h0a;
  localparam logic [5:0] OP_BSZ = 6'h0b;
  // instruction field positions
  localparam int OP_HI    = 23;
  localparam int OP_LO    = 18;
  localparam int K_HI     = 17;
  localparam int K_LO     = 14;
  localparam int X_HI     = 17;
  localparam int X_LO     = 15;
  localparam int I_BIT    = 14;
  localparam int M_HI     = 13;
  localparam int M_LO     = 0;
  localparam int XFER_BIT = 17;
  localparam int DIR_BIT  = 16;
  localparam int CMD_HI   = 15;
  localparam int CMD_LO   = 8;
  localparam int UNIT_HI  = 6;
  localparam int UNIT_LO  = 0;
  localparam int SAVE_HI  = 23;
  localparam int SAVE_LO  = 19;
  // state branch selector codes
  localparam logic [3:0] BOS_IE = 4'h8;
  localparam logic [3:0] BOS_OV = 4'h9;
  // addresses, steps and reset values
  localparam logic [13:0] ZERO_ADDR = 14'h0000;
  localparam logic [13:0] PC_STEP   = 14'h0001;
  localparam logic [13:0] ADDR_RST  = 14'h0000;
  localparam logic [23:0] WORD_RST  = 24'h000000;
  localparam logic [4:0]  FLAGS_RST = 5'h00;
  // indicators, packed in saved-word order
  typedef struct packed {
    logic ov;
    logic gt;
    logic eq;
    logic lt;
    logic cb;
  } bps_flags_t;
  // memory write request
  typedef struct packed {
    logic        we;
    logic [13:0] addr;
    logic [23:0] data;
  } bps_mem_t;
  // peripheral select bundle
  typedef struct packed {
    logic        sel;
    logic        xfer;
    logic        dir;
    logic [7:0]  cmd;
    logic [6:0]  unit;
    logic [23:0] wdata;
  } bps_per_t;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_PER  = 2'b10
  } bps_state_t;
endpackage

// [testbench/bps_unit_model.sv]
// peripheral unit model answering the select bundle of the exec block
`timescale 1ns/100ps
`default_nettype none
module bps_unit_model (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire bps_pkg::bps_per_t per_q,
  output logic [3:0]             per_status,
  output logic [23:0]            per_rdata,
  output logic [7:0]             seen_cmd,
  output logic [6:0]             seen_unit,
  output logic [23:0]            seen_wdata,
  output logic                   seen_wr
);
  logic [27:0] last_q;                                      // last answer given
  wire  [3:0]  stat = per_q.unit[3:0] ^ per_q.cmd[3:0];     // status from unit and command
  wire  [23:0] rd   = {8'h5e, per_q.cmd, 1'b0, per_q.unit}; // word for the core
  // answer only while selected; otherwise show the inverse so stale data never matches
  assign per_status = per_q.sel ? stat : ~last_q[27:24];
  assign per_rdata  = per_q.sel ? rd : ~last_q[23:0];
  // take command, unit and any outgoing word on each select
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q     <= 28'h0;
      seen_cmd   <= 8'h0;
      seen_unit  <= 7'h0;
      seen_wdata <= 24'h0;
      seen_wr    <= 1'b0;
    end
    else if (per_q.sel)
    begin
      last_q    <= {stat, rd};
      seen_cmd  <= per_q.cmd;                // command latched here
      seen_unit <= per_q.unit;
      seen_wr   <= per_q.xfer & ~per_q.dir;  // word to unit only
      if (per_q.xfer & ~per_q.dir)
        seen_wdata <= per_q.wdata;
    end
  end
endmodule // bps_unit_model
`default_nettype wire

// [testbench/bps_exec_tb.sv]
// self-checking bench for the branch, call, select and no-operation exec block
`timescale 1ns/100ps
`default_nettype none
module bps_exec_tb;
  logic                ref_clk = 1'b0, rst_n = 1'b0, issue = 1'b0, ie_flag = 1'b1;
  logic                flag_we = 1'b0, idx_we = 1'b0;
  logic [23:0]         instr = 24'h0, acc = 24'h0, ind_word = {5'h0b, 5'h0, 14'h0155};
  logic [13:0]         cur_pc = 14'h0040, idx_wdata = 14'h0;
  logic [7:0]          sw_flops = 8'ha5;
  logic [5:0]          console_sw_pin = 6'h2d;
  logic [2:0]          idx_sel = 3'h0;
  bps_pkg::bps_flags_t flag_wdata = 5'h0, flags_q;
  logic [3:0]          per_status, kk;
  logic [23:0]         per_rdata, seen_wdata, ad, acc_wdata_q, a;
  logic                ready_q, done_q, taken_q, acc_we_q, seen_wr, mw, aw, hit;
  logic [13:0]         next_pc_q;
  logic [7:0]          seen_cmd, c;
  logic [6:0]          seen_unit, u;
  logic [1:0]          jj;
  bps_pkg::bps_mem_t   mem_q, ms;
  bps_pkg::bps_per_t   per_q;
  logic [23:0]         av [4] = '{24'h000005, 24'h000000, 24'h800001, 24'h7ffffe};
  int                  miscompares = 0, checks_done = 0, cycles = 0, n;

  bps_exec uut (.ref_clk, .rst_n, .issue, .instr, .cur_pc, .ind_word, .acc, .sw_flops,
    .ie_flag, .console_sw_pin, .flag_we, .flag_wdata, .idx_we, .idx_sel, .idx_wdata,
    .per_status, .per_rdata, .ready_q, .done_q, .taken_q, .next_pc_q, .flags_q, .mem_q,
    .acc_we_q, .acc_wdata_q, .per_q);
  bps_unit_model unit_m (.ref_clk, .rst_n, .per_q, .per_status, .per_rdata, .seen_cmd,
    .seen_unit, .seen_wdata, .seen_wr);

  // free-running 20 MHz clock
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // issue one word, follow it to retirement and catch the one-cycle pulses
  task automatic run(input logic [23:0] i, input logic [23:0] av_i);
    @(posedge ref_clk);
    instr <= i;
    acc <= av_i;
    issue <= 1'b1;
    @(posedge ref_clk);
    issue <= 1'b0;
    n = 0;
    mw = 1'b0;
    aw = 1'b0;
    // outputs launched by the taking edge are looked at just after it
    repeat (4)
    begin
      #1;
      n++;
      if (mem_q.we === 1'b1)
      begin
        mw = 1'b1;
        ms = mem_q;
      end
      if (acc_we_q === 1'b1)
      begin
        aw = 1'b1;
        ad = acc_wdata_q;
      end
      if (done_q === 1'b1)
        break;
      @(posedge ref_clk);
    end
  endtask

  // core loads the indicators for one cycle
  task automatic setf(input bps_pkg::bps_flags_t f);
    @(posedge ref_clk);
    flag_we <= 1'b1;
    flag_wdata <= f;
    @(posedge ref_clk);
    flag_we <= 1'b0;
  endtask

  // conditional branch: one cycle, raw target on a hit, next word otherwise
  task automatic br(input logic [5:0] op, input logic [3:0] k, input logic h, input logic [23:0] v);
    run({op, k, 14'h0123}, v);
    chk("cycles", 24'h1, 24'(n));
    chk("taken", 24'(h), 24'(taken_q));
    chk("next_pc", h ? 24'h0123 : 24'h0041, 24'(next_pc_q));
    chk("ready", 24'h1, 24'(ready_q));
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    // big offsets in index registers 1-7 so stray indexing through them moves the target
    for (int x = 1; x < 8; x++)
    begin
      @(posedge ref_clk);
      idx_we <= 1'b1;
      idx_sel <= 3'(x);
      idx_wdata <= 14'h1000;
    end
    @(posedge ref_clk);
    idx_we <= 1'b0;
    // accumulator test, every selector against four values
    for (int j = 0; j < 4; j++)
      for (int k = 0; k < 16; k++)
      begin
        kk = 4'(k);
        a = av[j];
        hit = (kk[3] & ~a[23] & (|a)) | (kk[2] & ~(|a)) | (kk[1] & a[23]) | (kk[0] & a[0]);
        br(bps_pkg::OP_BAT, kk, hit, a);
      end
    // indicator branch, flag patterns against every selector
    for (int j = 0; j < 4; j++)
    begin
      setf(5'(j * 5));
      for (int k = 0; k < 16; k++)
      begin
        kk = 4'(k);
        br(bps_pkg::OP_BOI, kk, |(kk & 4'(j * 5)), 24'h0);
        chk("flags", 24'(j * 5), 24'(flags_q));
      end
    end
    // state branch: switches, enable, overflow and console switches
    for (int k = 0; k < 16; k++)
    begin
      kk = 4'(k);
      setf(5'h1f);
      br(bps_pkg::OP_BOS, kk, {6'h2d, 2'b11, 8'ha5} >> k, 24'h0);
      chk("flags", {19'h0, kk != 4'h9, 4'hf}, 24'(flags_q));
    end
    // calls with indexing, save word, two cycles
    setf(5'h15);
    run({bps_pkg::OP_BSM, 3'h1, 1'b0, 14'h0200}, 24'h0);
    chk("cycles", 24'h2, 24'(n));
    chk("we", 24'h1, 24'(mw));
    chk("addr", 24'h1200, 24'(ms.addr));
    chk("data", {5'h15, 5'h0, 14'h0041}, ms.data);
    chk("next_pc", 24'h1201, 24'(next_pc_q));
    run({bps_pkg::OP_BSZ, 3'h2, 1'b0, 14'h0300}, 24'h0);
    chk("cycles", 24'h2, 24'(n));
    chk("addr", 24'h0, {10'h0, mw ? ms.addr : 14'h3fff});
    chk("data", {5'h15, 5'h0, 14'h0041}, ms.data);
    chk("next_pc", 24'h1300, 24'(next_pc_q));
    chk("taken", 24'h1, 24'(taken_q));
    // indirect return restores the saved indicators
    run({bps_pkg::OP_BRU, 3'h0, 1'b1, 14'h0000}, 24'h0);
    chk("next_pc", 24'h0155, 24'(next_pc_q));
    chk("flags", 24'h0b, 24'(flags_q));
    // peripheral select in all four transfer modes
    setf(5'h10);
    for (int j = 0; j < 4; j++)
    begin
      jj = 2'(j);
      u = 7'h7c | 7'(j);
      c = 8'hc3 ^ 8'(j);
      run({bps_pkg::OP_SPU, jj, c, 1'b0, u}, 24'h9a5c3e);
      chk("cycles", 24'h2, 24'(n));
      chk("unit", 24'(u), 24'(seen_unit));
      chk("cmd", 24'(c), 24'(seen_cmd));
      chk("out", 24'(jj == 2'b10), 24'(seen_wr));
      if (jj == 2'b10)
        chk("wdata", 24'h9a5c3e, seen_wdata);
      chk("acc_we", 24'(jj == 2'b11), 24'(aw));
      if (jj == 2'b11)
        chk("acc_wdata", {8'h5e, c, 1'b0, u}, ad);
      chk("flags", {19'h0, 1'b1, u[3:0] ^ c[3:0]}, 24'(flags_q));
    end
    // no-operation leaves everything but the program counter
    setf(5'h0e);
    run({bps_pkg::OP_NOP, 18'h0}, 24'h0);
    chk("cycles", 24'h1, 24'(n));
    chk("side", 24'h0, {22'h0, mw, aw});
    chk("flags", 24'h0e, 24'(flags_q));
    chk("next_pc", 24'h0041, 24'(next_pc_q));
    complete_run;
  end
endmodule // bps_exec_tb
`default_nettype wire
